/* File: hdl/rec_top.sv */
`timescale 1ns/10ps
module rec_top #(
  parameter int         P_VARIANT   = 0,
  parameter logic [6:0] P_DEV_ADDR  = 7'h34,
  parameter int         P_NUM_BUCK  = rec_pkg::NUM_BUCK,
  parameter int         P_STEP_CYC  = rec_pkg::SLEW_STEP_CYC
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_scl,
  input  wire logic                                i_sda,
  output logic                                     o_sda_out,
  output logic                                     o_sda_oe_n,
  input  wire logic                                i_shared_linear_enable_pin,
  input  wire logic                                i_fixed_out_low,
  input  wire logic                                i_sel_out_low,
  input  wire rec_pkg::rec_sw_in_t [P_NUM_BUCK-1:0] i_buck_sw,
  output logic                                     o_fixed_linear_en,
  output logic                                     o_sel_linear_en,
  output logic [1:0]                               o_sel_linear_option,
  output logic [P_NUM_BUCK-1:0][4:0]               o_buck_ref_code,
  output rec_pkg::rec_mode_t [P_NUM_BUCK-1:0]      o_buck_mode,
  output rec_pkg::rec_sw_out_t [P_NUM_BUCK-1:0]    o_buck_sw
);

  logic [7:0]                     out_en_q;
  logic [7:0]                     start_wait_q;
  logic [7:0]                     lin_t2_q;
  logic [7:0]                     sw_mode_q;
  logic [7:0]                     ref_ctrl_q;
  logic [P_NUM_BUCK-1:0][4:0]     t1_q;
  logic [P_NUM_BUCK-1:0][4:0]     t2_q;
  logic [P_NUM_BUCK-1:0][4:0]     goal_q;
  logic [P_NUM_BUCK-1:0]          slew_dn;
  logic [P_NUM_BUCK-1:0]          slewing;
  logic [15:0]                    step_cnt_q;
  logic                           step_tick;
  logic [1:0]                     pin_sync_q;
  logic [1:0]                     fixed_low_q;
  logic [1:0]                     sel_low_q;
  logic [P_NUM_BUCK-1:0][2:0]     sw_sync1_q;
  logic [P_NUM_BUCK-1:0][2:0]     sw_sync2_q;
  logic                           pin;
  logic                           fixed_req;
  logic                           sel_req;
  logic                           fixed_wait;
  logic                           sel_wait;
  logic                           slew_go;
  logic [7:0]                     rd_addr;
  logic [7:0]                     rd_data;
  logic [7:0]                     status;
  rec_pkg::rec_wr_t               wr;

  //////////////////////////////////////////////////////////////////////////////
  rec_i2c_target #(
    .P_DEV_ADDR (P_DEV_ADDR)
  ) u_i2c (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .i_rd_data  (rd_data),
    .o_rd_addr  (rd_addr),
    .o_wr       (wr),
    .o_sda_out  (o_sda_out),
    .o_sda_oe_n (o_sda_oe_n)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Command registers take their new value in the cycle after the acknowledge.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      out_en_q     <= rec_pkg::REG_RESET;
      start_wait_q <= rec_pkg::REG_RESET;
      lin_t2_q     <= rec_pkg::REG_RESET;
      sw_mode_q    <= rec_pkg::REG_RESET;
    end else if (wr.valid) begin
      if (wr.addr == rec_pkg::ADDR_OUT_EN) begin
        out_en_q <= wr.data;
      end else if (wr.addr == rec_pkg::ADDR_START_WAIT) begin
        start_wait_q <= wr.data;
      end else if (wr.addr == rec_pkg::ADDR_LIN_T2) begin
        lin_t2_q <= wr.data;
      end else if (wr.addr == rec_pkg::ADDR_SW_MODE) begin
        sw_mode_q <= wr.data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // The go bit clears itself, so one write starts exactly one slew.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ref_ctrl_q <= rec_pkg::REG_RESET;
    end else if (wr.valid && wr.addr == rec_pkg::ADDR_REF_CTRL) begin
      ref_ctrl_q <= wr.data;
    end else begin
      ref_ctrl_q[rec_pkg::BIT_SLEW_GO] <= 1'b0;
    end
  end

  assign slew_go = ref_ctrl_q[rec_pkg::BIT_SLEW_GO];

  //////////////////////////////////////////////////////////////////////////////
  // Pin and comparator inputs come from outside the clock domain.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_sync_q  <= 2'h0;
      fixed_low_q <= 2'h0;
      sel_low_q   <= 2'h0;
    end else begin
      pin_sync_q  <= {pin_sync_q[0], i_shared_linear_enable_pin};
      fixed_low_q <= {fixed_low_q[0], i_fixed_out_low};
      sel_low_q   <= {sel_low_q[0], i_sel_out_low};
    end
  end

  assign pin       = pin_sync_q[1];
  assign fixed_req = pin | out_en_q[rec_pkg::BIT_FIXED];

  always_comb begin
    if (P_VARIANT != 0) begin
      sel_req = out_en_q[rec_pkg::BIT_SEL];
    end else if (lin_t2_q[rec_pkg::BIT_PIN_DETACH]) begin
      sel_req = out_en_q[rec_pkg::BIT_SEL];
    end else begin
      sel_req = pin | out_en_q[rec_pkg::BIT_SEL];
    end
  end

  // The second variant stores the wait choice with the opposite sense.
  always_comb begin
    if (P_VARIANT == rec_pkg::VARIANT_SECOND) begin
      fixed_wait = start_wait_q[rec_pkg::BIT_FIXED];
      sel_wait   = start_wait_q[rec_pkg::BIT_SEL];
    end else begin
      fixed_wait = ~start_wait_q[rec_pkg::BIT_FIXED];
      sel_wait   = ~start_wait_q[rec_pkg::BIT_SEL];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Once running, a regulator stays on even if its output later reads low.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fixed_linear_en <= 1'b0;
    end else if (!fixed_req) begin
      o_fixed_linear_en <= 1'b0;
    end else if (!fixed_wait || fixed_low_q[1]) begin
      o_fixed_linear_en <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sel_linear_en <= 1'b0;
    end else if (!sel_req) begin
      o_sel_linear_en <= 1'b0;
    end else if (!sel_wait || sel_low_q[1]) begin
      o_sel_linear_en <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sel_linear_option <= 2'h0;
    end else begin
      o_sel_linear_option <= lin_t2_q[rec_pkg::OPT_LSB +: 2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One shared step timer paces every buck reference by one code per tick.
  always_ff @(posedge i_clk) begin
    if (i_rst || step_tick) begin
      step_cnt_q <= 16'h0000;
    end else begin
      step_cnt_q <= step_cnt_q + 16'h0001;
    end
  end

  assign step_tick = (step_cnt_q == 16'(P_STEP_CYC - 1));

  genvar gi;
  generate
    for (gi = 0; gi < P_NUM_BUCK; gi++) begin : g_buck
      localparam logic [7:0] A1 = 8'(rec_pkg::ADDR_BUCK_T1 + gi * rec_pkg::BUCK_STRIDE);
      localparam logic [7:0] A2 = 8'(rec_pkg::ADDR_BUCK_T2 + gi * rec_pkg::BUCK_STRIDE);
      rec_pkg::rec_mode_t prog_mode;
      rec_pkg::rec_mode_t eff_mode;
      logic cyc;
      logic trip;
      logic zero;

      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          t1_q[gi] <= rec_pkg::BUCK_CODE_RESET;
          t2_q[gi] <= rec_pkg::BUCK_CODE_RESET;
        end else if (wr.valid && wr.addr == A1) begin
          t1_q[gi] <= wr.data[4:0];
        end else if (wr.valid && wr.addr == A2) begin
          t2_q[gi] <= wr.data[4:0];
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          goal_q[gi]          <= rec_pkg::BUCK_CODE_RESET;
          o_buck_ref_code[gi] <= rec_pkg::BUCK_CODE_RESET;
        end else begin
          if (slew_go) begin
            goal_q[gi] <= ref_ctrl_q[gi] ? t2_q[gi] : t1_q[gi];
          end
          if (step_tick && slew_dn[gi]) begin
            o_buck_ref_code[gi] <= o_buck_ref_code[gi] - 5'h01;
          end else if (step_tick && slewing[gi]) begin
            o_buck_ref_code[gi] <= o_buck_ref_code[gi] + 5'h01;
          end
        end
      end

      assign slew_dn[gi] = o_buck_ref_code[gi] > goal_q[gi];
      assign slewing[gi] = o_buck_ref_code[gi] != goal_q[gi];

      // The unused code 11 runs as pulse-skipping rather than something undefined.
      always_comb begin
        case (sw_mode_q[2*gi +: 2])
          rec_pkg::REC_MODE_BURST: prog_mode = rec_pkg::REC_MODE_BURST;
          rec_pkg::REC_MODE_FCM:   prog_mode = rec_pkg::REC_MODE_FCM;
          default:                 prog_mode = rec_pkg::REC_MODE_SKIP;
        endcase
      end
      assign eff_mode  = slew_dn[gi] ? rec_pkg::REC_MODE_FCM : prog_mode;

      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          o_buck_mode[gi] <= rec_pkg::REC_MODE_SKIP;
        end else begin
          o_buck_mode[gi] <= eff_mode;
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          sw_sync1_q[gi] <= 3'h0;
          sw_sync2_q[gi] <= 3'h0;
        end else begin
          sw_sync1_q[gi] <= i_buck_sw[gi];
          sw_sync2_q[gi] <= sw_sync1_q[gi];
        end
      end

      assign cyc  = sw_sync2_q[gi][2];
      assign trip = sw_sync2_q[gi][1];
      assign zero = sw_sync2_q[gi][0];

      // The trip wins over a coincident cycle start while the main switch is on, so it never sticks on.
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          o_buck_sw[gi] <= '0;
        end else if (trip && o_buck_sw[gi].main_on) begin
          o_buck_sw[gi].main_on <= 1'b0;
          o_buck_sw[gi].rect_on <= 1'b1;
        end else if (cyc) begin
          o_buck_sw[gi].main_on <= 1'b1;
          o_buck_sw[gi].rect_on <= 1'b0;
        end else if (zero && eff_mode != rec_pkg::REC_MODE_FCM) begin
          o_buck_sw[gi].rect_on <= 1'b0;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  assign status = {2'h0, pin, slewing[2:0], o_sel_linear_en, o_fixed_linear_en};

  always_comb begin
    rd_data = 8'h00;
    if (rd_addr == rec_pkg::ADDR_STATUS) begin
      rd_data = status;
    end else if (rd_addr == rec_pkg::ADDR_OUT_EN) begin
      rd_data = out_en_q;
    end else if (rd_addr == rec_pkg::ADDR_START_WAIT) begin
      rd_data = start_wait_q;
    end else if (rd_addr == rec_pkg::ADDR_LIN_T2) begin
      rd_data = lin_t2_q;
    end else if (rd_addr == rec_pkg::ADDR_SW_MODE) begin
      rd_data = sw_mode_q;
    end else if (rd_addr == rec_pkg::ADDR_REF_CTRL) begin
      rd_data = ref_ctrl_q;
    end else begin
      for (int k = 0; k < P_NUM_BUCK; k++) begin
        if (rd_addr == 8'(rec_pkg::ADDR_BUCK_T1 + k * rec_pkg::BUCK_STRIDE)) begin
          rd_data = {3'h0, t1_q[k]};
        end else if (rd_addr == 8'(rec_pkg::ADDR_BUCK_T2 + k * rec_pkg::BUCK_STRIDE)) begin
          rd_data = {3'h0, t2_q[k]};
        end
      end
    end
  end

endmodule : rec_top

/* File: hdl/rec_pkg.sv */
package rec_pkg;

  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          SLEW_STEP_NS    = 1786;
  localparam int          SLEW_STEP_CYC   = SLEW_STEP_NS / CLK_PERIOD_NS;
  localparam int          NUM_BUCK        = 3;

  localparam logic [7:0]  ADDR_STATUS     = 8'h02;
  localparam logic [7:0]  ADDR_OUT_EN     = 8'h10;
  localparam logic [7:0]  ADDR_SW_MODE    = 8'h12;
  localparam logic [7:0]  ADDR_START_WAIT = 8'h13;
  localparam logic [7:0]  ADDR_REF_CTRL   = 8'h20;
  localparam logic [7:0]  ADDR_BUCK_T1    = 8'h23;
  localparam logic [7:0]  ADDR_BUCK_T2    = 8'h24;
  localparam logic [7:0]  BUCK_STRIDE     = 8'h02;
  localparam logic [7:0]  ADDR_LIN_T2     = 8'h33;

  localparam int          BIT_FIXED       = 5;
  localparam int          BIT_SEL         = 6;
  localparam int          BIT_PIN_DETACH  = 7;
  localparam int          OPT_LSB         = 5;
  localparam int          BIT_SLEW_GO     = 3;
  localparam int          VARIANT_SECOND  = 2;

  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [4:0]  BUCK_CODE_RESET = 5'h19;

  typedef enum logic [1:0] {
    REC_MODE_SKIP  = 2'h0,
    REC_MODE_BURST = 2'h1,
    REC_MODE_FCM   = 2'h2
  } rec_mode_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } rec_wr_t;

  typedef struct packed {
    logic cycle_start;
    logic peak_trip;
    logic zero_cross;
  } rec_sw_in_t;

  typedef struct packed {
    logic main_on;
    logic rect_on;
  } rec_sw_out_t;

endpackage : rec_pkg

/* File: hdl/rec_i2c_target.sv */
`timescale 1ns/10ps
module rec_i2c_target #(
  parameter logic [6:0] P_DEV_ADDR = 7'h34
) (
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  input  wire logic           i_scl,
  input  wire logic           i_sda,
  input  wire logic [7:0]     i_rd_data,
  output logic [7:0]          o_rd_addr,
  output rec_pkg::rec_wr_t    o_wr,
  output logic                o_sda_out,
  output logic                o_sda_oe_n
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA, ST_MACK} rec_i2c_st_t;

  rec_i2c_st_t state_q;
  rec_i2c_st_t next_q;
  logic [1:0]  scl_sync_q;
  logic [1:0]  sda_sync_q;
  logic        scl_p_q;
  logic        sda_p_q;
  logic [7:0]  sr_q;
  logic [7:0]  tx_q;
  logic [3:0]  cnt_q;
  logic        ack_q;
  logic        ld_q;
  logic [7:0]  ptr_q;
  logic        scl_s;
  logic        sda_s;
  logic        start_ev;
  logic        stop_ev;
  logic        scl_rise;
  logic        scl_fall;

  //////////////////////////////////////////////////////////////////////////////
  // Pins cross two flops before anything looks at them.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_p_q    <= scl_sync_q[1];
      sda_p_q    <= sda_sync_q[1];
    end
  end

  assign scl_s    = scl_sync_q[1];
  assign sda_s    = sda_sync_q[1];
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign o_rd_addr = ptr_q;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    o_wr.valid <= 1'b0;
    if (i_rst) begin
      state_q    <= ST_IDLE;
      next_q     <= ST_IDLE;
      sr_q       <= 8'h00;
      tx_q       <= 8'h00;
      cnt_q      <= 4'h0;
      ack_q      <= 1'b0;
      ld_q       <= 1'b0;
      ptr_q      <= 8'h00;
      o_wr       <= '0;
      o_sda_out  <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else if (start_ev) begin
      state_q    <= ST_ADDR;
      cnt_q      <= 4'h0;
      ack_q      <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else if (stop_ev) begin
      state_q    <= ST_IDLE;
      o_sda_oe_n <= 1'b1;
    end else begin
      case (state_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && cnt_q < 4'h8) begin
            sr_q  <= {sr_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8 && !ack_q) begin
            ack_q      <= 1'b1;
            o_sda_oe_n <= 1'b0;
            if (state_q == ST_ADDR) begin
              if (sr_q[7:1] != P_DEV_ADDR) begin
                state_q    <= ST_IDLE;
                o_sda_oe_n <= 1'b1;
              end
              next_q <= sr_q[0] ? ST_RDATA : ST_REG;
            end else if (state_q == ST_REG) begin
              ptr_q  <= sr_q;
              next_q <= ST_WDATA;
            end else begin
              // The byte is committed at its acknowledge, never earlier.
              o_wr.valid <= 1'b1;
              o_wr.addr  <= ptr_q;
              o_wr.data  <= sr_q;
              ptr_q      <= ptr_q + 8'h01;
              next_q     <= ST_WDATA;
            end
          end else if (scl_fall && cnt_q == 4'h8) begin
            ack_q   <= 1'b0;
            cnt_q   <= 4'h0;
            state_q <= next_q;
            if (next_q == ST_RDATA) begin
              o_sda_oe_n <= i_rd_data[7];
              tx_q       <= {i_rd_data[6:0], 1'b0};
              ptr_q      <= ptr_q + 8'h01;
            end else begin
              o_sda_oe_n <= 1'b1;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            o_sda_oe_n <= 1'b1;
            state_q    <= ST_MACK;
          end else if (scl_fall) begin
            o_sda_oe_n <= tx_q[7];
            tx_q       <= {tx_q[6:0], 1'b0};
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            ld_q <= ~sda_s;
            if (sda_s) begin
              state_q <= ST_IDLE;
            end
          end else if (scl_fall && ld_q) begin
            ld_q       <= 1'b0;
            cnt_q      <= 4'h0;
            state_q    <= ST_RDATA;
            o_sda_oe_n <= i_rd_data[7];
            tx_q       <= {i_rd_data[6:0], 1'b0};
            ptr_q      <= ptr_q + 8'h01;
          end
        end
        default: begin
          o_sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

endmodule : rec_i2c_target

/* File: test/rec_checker.sv */
`timescale 1ns/10ps
module rec_checker #(
  parameter int P_NUM_BUCK = 3,
  parameter int P_STEP_CYC = 4
) (
  input wire logic                                  i_clk,
  input wire logic                                  i_rst,
  input wire logic                                  i_scl,
  input wire logic                                  o_sda_out,
  input wire logic                                  o_sda_oe_n,
  input wire logic                                  i_shared_linear_enable_pin,
  input wire logic                                  i_fixed_out_low,
  input wire rec_pkg::rec_sw_in_t [P_NUM_BUCK-1:0]  i_buck_sw,
  input wire logic                                  o_fixed_linear_en,
  input wire logic [P_NUM_BUCK-1:0][4:0]            o_buck_ref_code,
  input wire rec_pkg::rec_mode_t [P_NUM_BUCK-1:0]   o_buck_mode,
  input wire rec_pkg::rec_sw_out_t [P_NUM_BUCK-1:0] o_buck_sw
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Cycles since the first reference last moved; saturates so long idle spans stay legal.
  logic [7:0] gap_q;
  always_ff @(posedge i_clk) begin
    if (i_rst || $changed(o_buck_ref_code[0])) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sda_open_drain_a: assert property (o_sda_out == 1'b0) else $error("sda data not low");
  sda_scl_low_a: assert property ($changed(o_sda_oe_n) |-> !i_scl) else $error("sda moved with scl high");
  pin_fixed_on_a: assert property ((i_shared_linear_enable_pin && i_fixed_out_low)[*5]
    |-> o_fixed_linear_en) else $error("fixed enable missing");
  ref_step_a: assert property ($changed(o_buck_ref_code[0]) |->
    (o_buck_ref_code[0] == $past(o_buck_ref_code[0]) + 5'h01) ||
    (o_buck_ref_code[0] + 5'h01 == $past(o_buck_ref_code[0]))) else $error("ref step not one code");
  ref_gap_a: assert property ($changed(o_buck_ref_code[0]) |-> gap_q >= P_STEP_CYC - 1)
    else $error("ref stepped too soon");
  down_fcm_a: assert property ((o_buck_ref_code[0] < $past(o_buck_ref_code[0])) |->
    o_buck_mode[0] == rec_pkg::REC_MODE_FCM) else $error("down slew not continuous");
  sw_exclusive_a: assert property (!(o_buck_sw[0].main_on && o_buck_sw[0].rect_on))
    else $error("main and rectifier both on");
  start_main_a: assert property ((i_buck_sw[0] == 3'b100)[*4] |=>
    o_buck_sw[0].main_on && !o_buck_sw[0].rect_on) else $error("cycle start missed");
  trip_off_a: assert property ((i_buck_sw[0] == 3'b010)[*4] |=> !o_buck_sw[0].main_on)
    else $error("peak trip missed");
  zero_rect_a: assert property ((i_buck_sw[0] == 3'b001 && o_buck_mode[0] == rec_pkg::REC_MODE_SKIP)[*4]
    |=> !o_buck_sw[0].rect_on) else $error("zero cross missed");

  cover property (o_buck_ref_code[0] < $past(o_buck_ref_code[0]));
  cover property ($rose(o_fixed_linear_en));
  cover property ($rose(o_buck_sw[0].rect_on));
endmodule : rec_checker

bind rec_top rec_checker #(.P_NUM_BUCK(P_NUM_BUCK), .P_STEP_CYC(P_STEP_CYC)) chk (.i_clk, .i_rst, .i_scl,
  .o_sda_out, .o_sda_oe_n, .i_shared_linear_enable_pin, .i_fixed_out_low, .i_buck_sw, .o_fixed_linear_en,
  .o_buck_ref_code, .o_buck_mode, .o_buck_sw);

/* File: test/rec_i2c_host.sv */
`timescale 1ns/10ps
module rec_i2c_host (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  task automatic hc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : hc

  // Ten cycles each phase keeps well above the six the synchronisers need.
  task automatic bit_io(input logic b, output logic r);
    o_sda_pull <= !b;
    hc(5);
    o_scl <= 1'b1;
    hc(5);
    r = i_sda;
    hc(5);
    o_scl <= 1'b0;
    hc(5);
  endtask : bit_io

  task automatic start();
    if (!o_scl) begin
      o_sda_pull <= 1'b0;
      hc(5);
      o_scl <= 1'b1;
      hc(10);
    end
    o_sda_pull <= 1'b1;
    hc(10);
    o_scl <= 1'b0;
    hc(5);
  endtask : start

  task automatic stop();
    o_sda_pull <= 1'b1;
    hc(5);
    o_scl <= 1'b1;
    hc(10);
    o_sda_pull <= 1'b0;
    hc(10);
  endtask : stop

  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = !r;
  endtask : xfer

  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2;
    start();
    xfer({dev, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    xfer(d, 1'b1, q, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : wr

  task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2, k3;
    start();
    xfer({dev, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    start();
    xfer({dev, 1'b1}, 1'b1, q, k2);
    xfer(8'hff, 1'b1, d, k3);
    stop();
    ok = k0 & k1 & k2;
  endtask : rd
endmodule : rec_i2c_host

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
  localparam int          NV  = 3;
  localparam logic [6:0]  DEV = 7'h34;
  localparam logic [7:0]  RA [3] = '{rec_pkg::ADDR_OUT_EN, rec_pkg::ADDR_START_WAIT, rec_pkg::ADDR_LIN_T2};
  logic                          clk, rst, scl, pull, sda, pin, f_low, s_low;
  rec_pkg::rec_sw_in_t [2:0]     bsw;
  logic [NV-1:0]                 oe_n, so, f_en, s_en;
  logic [NV-1:0][1:0]            opt;
  logic [NV-1:0][2:0][4:0]       code;
  rec_pkg::rec_mode_t [2:0]      mode [NV];
  rec_pkg::rec_sw_out_t [2:0]    swo [NV];
  int                            num_errors = 0, tests_run = 0, cyc = 0;
  int                            rv [3], ef [NV], es [NV];
  logic [31:0]                   seed, k;

  // Open-drain bus with a pull-up: high unless some party pulls it.
  assign sda = ~pull & (&oe_n);
  rec_i2c_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
  for (genvar v = 0; v < NV; v++) begin : g_v
    rec_top #(.P_VARIANT(v), .P_STEP_CYC(4)) dut (.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
      .o_sda_out(so[v]), .o_sda_oe_n(oe_n[v]), .i_shared_linear_enable_pin(pin), .i_fixed_out_low(f_low),
      .i_sel_out_low(s_low), .i_buck_sw(bsw), .o_fixed_linear_en(f_en[v]), .o_sel_linear_en(s_en[v]),
      .o_sel_linear_option(opt[v]), .o_buck_ref_code(code[v]), .o_buck_mode(mode[v]), .o_buck_sw(swo[v]));
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic cw(input int n);
    repeat (n) @(posedge clk);
  endtask : cw

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr(DEV, a, d, ok);
    check(ok, 1'b1);
    cw(3);
  endtask : w

  task automatic r(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.rd(DEV, a, d, ok);
    check(d, e);
    check(ok, 1'b1);
  endtask : r

  // Enable model: a waiting start latches on once the output is seen low.
  task automatic cmp_en();
    int rf, rs, wf, ws;
    for (int v = 0; v < NV; v++) begin
      rf = pin | rv[0][5];
      rs = (v == 0 && !rv[2][7] && pin) | rv[0][6];
      wf = (v == 2) ? rv[1][5] : !rv[1][5];
      ws = (v == 2) ? rv[1][6] : !rv[1][6];
      ef[v] = rf & (ef[v] | !wf | f_low);
      es[v] = rs & (es[v] | !ws | s_low);
      check(f_en[v], ef[v]);
      check(s_en[v], es[v]);
      check(opt[v], rv[2][6:5]);
    end
  endtask : cmp_en

  task automatic sw(input logic [2:0] s, input logic em, input logic er);
    bsw <= {3{s}};
    cw(4);
    bsw <= '0;
    cw(5);
    for (int v = 0; v < NV; v++) begin
      for (int b = 0; b < 3; b++) begin
        check({swo[v][b].main_on, swo[v][b].rect_on}, {em, er});
      end
    end
  endtask : sw

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    pin = 1'b0;
    f_low = 1'b0;
    s_low = 1'b0;
    bsw = '0;
    seed = 32'hfc2e_51fb;
    rv = '{default: 0};
    ef = '{default: 0};
    es = '{default: 0};
    cw(8);
    rst <= 1'b0;
    cw(4);
    for (int j = 0; j < 3; j++) r(RA[j], 8'h00);
    for (int b = 0; b < 3; b++) begin
      r(rec_pkg::ADDR_BUCK_T1 + 8'(2 * b), 8'h19);
      r(rec_pkg::ADDR_BUCK_T2 + 8'(2 * b), 8'h19);
      check(code[0][b], 5'h19);
    end
    r(8'hf0, 8'h00);
    host.wr(7'h35, RA[0], 8'hff, k[0]);
    check(k[0], 1'b0);
    cmp_en();
    for (int i = 0; i < 20; i++) begin
      k = xs();
      pin <= k[0];
      f_low <= k[1];
      s_low <= k[2];
      cw(8);
      cmp_en();
      rv[k[9:8] % 3] = int'(xs() & 32'h0000_00ff);
      w(RA[k[9:8] % 3], 8'(rv[k[9:8] % 3]));
      cmp_en();
      r(RA[k[9:8] % 3], 8'(rv[k[9:8] % 3]));
    end
    for (int m = 0; m < 3; m++) begin
      w(rec_pkg::ADDR_SW_MODE, 8'(m * 21));
      for (int v = 0; v < NV; v++) begin
        for (int b = 0; b < 3; b++) check(mode[v][b], 8'(m));
      end
    end
    w(rec_pkg::ADDR_SW_MODE, 8'h00);
    sw(3'b100, 1'b1, 1'b0);
    sw(3'b010, 1'b0, 1'b1);
    sw(3'b001, 1'b0, 1'b0);
    w(rec_pkg::ADDR_BUCK_T2, 8'h02);
    w(rec_pkg::ADDR_REF_CTRL, 8'h09);
    for (int i = 0; i < 300 && code[0][0] != 5'h02; i++) begin
      check(mode[0][0], rec_pkg::REC_MODE_FCM);
      cw(1);
    end
    cw(3);
    check(code[0][0], 5'h02);
    check(code[0][1], 5'h19);
    check(mode[0][0], rec_pkg::REC_MODE_SKIP);
    w(rec_pkg::ADDR_REF_CTRL, 8'h08);
    check(mode[0][0], rec_pkg::REC_MODE_SKIP);
    for (int i = 0; i < 300 && code[0][0] != 5'h19; i++) cw(1);
    check(code[0][0], 5'h19);
    w(rec_pkg::ADDR_SW_MODE, 8'h2a);
    sw(3'b100, 1'b1, 1'b0);
    sw(3'b010, 1'b0, 1'b1);
    sw(3'b001, 1'b0, 1'b1);
    print_verdict();
  end
endmodule : tb
